// File: fwp_consts.vh
`ifndef FWP_CONSTS_VH
`define FWP_CONSTS_VH

// ==========================================
// instruction opcodes
`define FWP_OP_WRITE_ENABLE_CMD      8'h06
`define FWP_OP_WRDI      8'h04
`define FWP_OP_STATUS_WRITE_CMD      8'h01
`define FWP_OP_WRFR      8'h42
`define FWP_OP_PP        8'h02
`define FWP_OP_PP4       8'h12
`define FWP_OP_PPQ_A     8'h32
`define FWP_OP_PPQ_B     8'h38
`define FWP_OP_PPQ4_A    8'h34
`define FWP_OP_PPQ4_B    8'h3e
`define FWP_OP_SE_A      8'hd7
`define FWP_OP_SE_B      8'h20
`define FWP_OP_SE4       8'h21
`define FWP_OP_BE32      8'h52
`define FWP_OP_BE32_4    8'h5c
`define FWP_OP_BE64      8'hd8
`define FWP_OP_BE64_4    8'hdc
`define FWP_OP_CE_A      8'hc7
`define FWP_OP_CE_B      8'h60
`define FWP_OP_RP_NV     8'h65
`define FWP_OP_RP_V      8'h63
`define FWP_OP_RP_V_ALT  8'hc0
`define FWP_OP_ERP_NV    8'h85
`define FWP_OP_ERP_V     8'h83
`define FWP_OP_DLP_NV    8'h43
`define FWP_OP_DLP_V     8'h4a
`define FWP_OP_BANK_NV   8'h18
`define FWP_OP_BANK_V    8'hc5
`define FWP_OP_BANK_ALT  8'h17
`define FWP_OP_DYN_A     8'hfb
`define FWP_OP_DYN_B     8'he1
`define FWP_OP_PERS_A    8'hfd
`define FWP_OP_PERS_B    8'he3
`define FWP_OP_PERS_ER   8'he4

// ==========================================
// status and function register fields
`define FWP_ST_WIP       0
`define FWP_ST_WEL       1
`define FWP_ST_BP_LO     2
`define FWP_ST_BP_HI     5
`define FWP_ST_QE        6
`define FWP_ST_STATUS_WRITE_DISABLE      7
`define FWP_ST_RST       8'h00
`define FWP_FN_TBS       1

// ==========================================
// block geometry
`define FWP_BLK_SHIFT    16
`define FWP_BLK_TOTAL    12'h800
`define FWP_CNT_12       12'h600
`define FWP_CNT_13       12'h700
`define FWP_CNT_14       12'h780

// ==========================================
// apb register map
`define FWP_A_STATUS     4'h0
`define FWP_A_FUNC       4'h4
`define FWP_A_EVENT      4'h8
`define FWP_A_LAST       4'hc
`define FWP_EV_GO        0
`define FWP_EV_WEL       1
`define FWP_EV_PROT      2
`define FWP_EV_STATUS_WRITE_DISABLE      3
`define FWP_EV_BUSY      4

`endif

// File: fwp_range_check.v
`timescale 1ns/1ps
`include "fwp_consts.vh"

module fwp_range_check #(
  parameter BLK_W = 11
) (
  input  wire [3:0]       bp_code,
  input  wire             bottom_sel,
  input  wire [BLK_W-1:0] blk_idx,
  output reg  [BLK_W:0]   prot_count,
  output reg              blk_protected
);

  // ==========================================
  // protected block count per code
  always @* begin
    case (bp_code)
      4'h0: prot_count = {(BLK_W+1){1'b0}};
      4'hc: prot_count = `FWP_CNT_12;
      4'hd: prot_count = `FWP_CNT_13;
      4'he: prot_count = `FWP_CNT_14;
      4'hf: prot_count = `FWP_BLK_TOTAL;
      default: prot_count = {{BLK_W{1'b0}}, 1'b1} << (bp_code - 4'h1);
    endcase
  end

  // ==========================================
  // compare target block against the range
  always @* begin
    if (bottom_sel) begin
      blk_protected = ({1'b0, blk_idx} < prot_count);
    end else begin
      blk_protected = ({1'b0, blk_idx} >= (`FWP_BLK_TOTAL - prot_count)) &&
                      (prot_count != {(BLK_W+1){1'b0}});
    end
  end

endmodule // fwp_range_check

// File: fwp_write_protect.v
`timescale 1ns/1ps
`include "fwp_consts.vh"

// Functional notes
// - modifying instructions need a prior write-enable; ignored while latch clear
// - page program opcodes 02h 12h 32h/38h 34h/3Eh need the latch
// - 4KB sector erase D7h/20h and 21h need the latch
// - 32KB block erase 52h and 5Ch need the latch
// - 64KB block erase D8h and DCh need the latch
// - chip erase C7h/60h ignored unless all protect bits are zero
// - read parameter writes 65h and 63h need the latch
// - extended read parameter writes 85h and 83h need the latch
// - training pattern writes 43h and 4Ah need the latch
// - bank register writes 18h and C5h need the latch
// - alternate volatile opcodes C0h and 17h run without the latch
// - dynamic sector lock writes FBh and E1h need the latch
// - persistent lock writes FDh E3h and erase E4h need the latch
// - program or erase inside the protected area is inhibited
// - top select: code n protects highest 2^(n-1) blocks ending at 2047
// - codes 12-14 protect 1536/1792/1920 blocks; code 15 protects all
// - bottom select protects the same counts starting from block 0
// - disable bit set, protect pin low and quad enable clear: status write ignored
// - protect pin high or disable bit clear: status write allowed
// - quad enable clear uses protect/hold pins; set makes them data lanes
// - write-enable opcode 06h sets the latch
// - latch clears when a non-volatile write, program or erase completes
// - top/bottom select defaults top and is one-time programmable to bottom

module fwp_write_protect #(
  parameter ADDR_W = 27
) (
  input  wire              ref_clk,
  input  wire              reset_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata_r,
  output reg               pready_r,
  output reg               pslverr_r,
  input  wire              cmd_valid,
  input  wire [7:0]        cmd_opcode,
  input  wire [ADDR_W-1:0] cmd_addr,
  input  wire [7:0]        cmd_data,
  input  wire              op_done,
  input  wire              wp_n_pin,
  input  wire              hold_n_pin,
  output reg               cmd_go_r,
  output reg               cmd_drop_r,
  output reg  [7:0]        status_r,
  output reg               tbs_r,
  output reg               quad_lanes_r,
  output reg               hold_active_r,
  output reg               wp_active_r
);

  localparam BLK_W = ADDR_W - `FWP_BLK_SHIFT;

  // opcode classes
  localparam [3:0] CL_NONE   = 4'h0;
  localparam [3:0] CL_PROG   = 4'h1;
  localparam [3:0] CL_ERASE  = 4'h2;
  localparam [3:0] CL_CHIP   = 4'h3;
  localparam [3:0] CL_NVREG  = 4'h4;
  localparam [3:0] CL_VREG   = 4'h5;
  localparam [3:0] CL_FREE   = 4'h6;
  localparam [3:0] CL_WRITE_ENABLE_CMD   = 4'h7;
  localparam [3:0] CL_WRDI   = 4'h8;
  localparam [3:0] CL_STATUS_WRITE_CMD   = 4'h9;
  localparam [3:0] CL_WRFR   = 4'ha;

  // ==========================================
  // opcode classification
  function [3:0] op_class;
    input [7:0] op;
    begin
      case (op)
        `FWP_OP_PP, `FWP_OP_PP4,
        `FWP_OP_PPQ_A, `FWP_OP_PPQ_B,
        `FWP_OP_PPQ4_A, `FWP_OP_PPQ4_B: op_class = CL_PROG;
        `FWP_OP_SE_A, `FWP_OP_SE_B, `FWP_OP_SE4: op_class = CL_ERASE;
        `FWP_OP_BE32, `FWP_OP_BE32_4: op_class = CL_ERASE;
        `FWP_OP_BE64, `FWP_OP_BE64_4: op_class = CL_ERASE;
        `FWP_OP_CE_A, `FWP_OP_CE_B: op_class = CL_CHIP;
        `FWP_OP_RP_NV: op_class = CL_NVREG;
        `FWP_OP_RP_V: op_class = CL_VREG;
        `FWP_OP_ERP_NV: op_class = CL_NVREG;
        `FWP_OP_ERP_V: op_class = CL_VREG;
        `FWP_OP_DLP_NV: op_class = CL_NVREG;
        `FWP_OP_DLP_V: op_class = CL_VREG;
        `FWP_OP_BANK_NV: op_class = CL_NVREG;
        `FWP_OP_BANK_V: op_class = CL_VREG;
        `FWP_OP_RP_V_ALT, `FWP_OP_BANK_ALT: op_class = CL_FREE;
        `FWP_OP_DYN_A, `FWP_OP_DYN_B: op_class = CL_VREG;
        `FWP_OP_PERS_A, `FWP_OP_PERS_B,
        `FWP_OP_PERS_ER: op_class = CL_NVREG;
        `FWP_OP_WRITE_ENABLE_CMD: op_class = CL_WRITE_ENABLE_CMD;
        `FWP_OP_WRDI: op_class = CL_WRDI;
        `FWP_OP_STATUS_WRITE_CMD: op_class = CL_STATUS_WRITE_CMD;
        `FWP_OP_WRFR: op_class = CL_WRFR;
        default: op_class = CL_NONE;
      endcase
    end
  endfunction

  // ==========================================
  // pin synchronisers (three stages, change on agreement)
  reg  [2:0] wp_sync_r;
  reg  [2:0] hold_sync_r;
  reg        wp_level_r;
  reg        hold_level_r;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_sync_r    <= 3'h7;
      hold_sync_r  <= 3'h7;
      wp_level_r   <= 1'b1;
      hold_level_r <= 1'b1;
    end else begin
      wp_sync_r   <= {wp_sync_r[1:0], wp_n_pin};
      hold_sync_r <= {hold_sync_r[1:0], hold_n_pin};
      if (wp_sync_r[1] == wp_sync_r[2]) begin
        wp_level_r <= wp_sync_r[2];
      end
      if (hold_sync_r[1] == hold_sync_r[2]) begin
        hold_level_r <= hold_sync_r[2];
      end
    end
  end

  // ==========================================
  // protection state
  reg         wel_r;
  reg         busy_r;
  reg  [3:0]  bp_r;
  reg         qe_r;
  reg         status_write_disable_r;
  reg  [4:0]  event_r;
  reg  [7:0]  last_op_r;
  reg  [4:0]  event_nxt;

  wire [3:0]  cls = op_class(cmd_opcode);
  wire [BLK_W-1:0] tgt_blk = cmd_addr[ADDR_W-1:`FWP_BLK_SHIFT];
  wire [BLK_W:0]   prot_count;
  wire        blk_prot;

  fwp_range_check #(
    .BLK_W         (BLK_W)
  ) u_range (
    .bp_code       (bp_r),
    .bottom_sel    (tbs_r),
    .blk_idx       (tgt_blk),
    .prot_count    (prot_count),
    .blk_protected (blk_prot)
  );

  // hardware protection mode: only meaningful while pin acts as protect
  wire hw_locked = status_write_disable_r & ~wp_level_r & ~qe_r;

  // ==========================================
  // decision on one instruction
  reg  go;
  reg  drop;
  reg  why_wel;
  reg  why_prot;
  reg  why_status_write_disable;

  always @* begin
    go       = 1'b0;
    drop     = 1'b0;
    why_wel  = 1'b0;
    why_prot = 1'b0;
    why_status_write_disable = 1'b0;
    if (cmd_valid && cls != CL_NONE) begin
      if (busy_r) begin
        drop = 1'b1;
      end else begin
        case (cls)
          CL_WRITE_ENABLE_CMD, CL_WRDI, CL_FREE: begin
            go = 1'b1;
          end
          CL_PROG, CL_ERASE: begin
            if (!wel_r) begin
              why_wel = 1'b1;
            end else if (blk_prot) begin
              why_prot = 1'b1;
            end else begin
              go = 1'b1;
            end
          end
          CL_CHIP: begin
            if (!wel_r) begin
              why_wel = 1'b1;
            end else if (bp_r != 4'h0) begin
              why_prot = 1'b1;
            end else begin
              go = 1'b1;
            end
          end
          CL_STATUS_WRITE_CMD: begin
            if (!wel_r) begin
              why_wel = 1'b1;
            end else if (hw_locked) begin
              why_status_write_disable = 1'b1;
            end else begin
              go = 1'b1;
            end
          end
          default: begin
            if (!wel_r) begin
              why_wel = 1'b1;
            end else begin
              go = 1'b1;
            end
          end
        endcase
        drop = why_wel | why_prot | why_status_write_disable;
      end
    end
  end

  // long operations raise busy and end on op_done
  wire starts_long = go && (cls == CL_PROG || cls == CL_ERASE ||
                            cls == CL_CHIP || cls == CL_NVREG ||
                            cls == CL_STATUS_WRITE_CMD || cls == CL_WRFR);

  // ==========================================
  // apb decode
  wire       apb_setup  = psel & ~penable;
  wire       apb_done   = psel & penable & pready_r;
  wire       addr_hit   = (paddr[31:4] == 28'h0000000) && (paddr[1:0] == 2'h0);
  wire       ev_clr_wr  = apb_done & pwrite & ~pslverr_r &
                          (paddr[3:0] == `FWP_A_EVENT);

  // software clears with ones, a new event in the same cycle wins
  always @* begin
    event_nxt = event_r;
    if (ev_clr_wr) begin
      event_nxt = event_r & ~pwdata[4:0];
    end
    if (go) begin
      event_nxt[`FWP_EV_GO] = 1'b1;
    end
    if (why_wel) begin
      event_nxt[`FWP_EV_WEL] = 1'b1;
    end
    if (why_prot) begin
      event_nxt[`FWP_EV_PROT] = 1'b1;
    end
    if (why_status_write_disable) begin
      event_nxt[`FWP_EV_STATUS_WRITE_DISABLE] = 1'b1;
    end
    if (drop && busy_r) begin
      event_nxt[`FWP_EV_BUSY] = 1'b1;
    end
  end

  // ==========================================
  // state update
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wel_r     <= 1'b0;
      busy_r    <= 1'b0;
      bp_r      <= 4'h0;
      qe_r      <= 1'b0;
      status_write_disable_r    <= 1'b0;
      tbs_r     <= 1'b0;
      event_r   <= 5'h00;
      last_op_r <= 8'h00;
      cmd_go_r  <= 1'b0;
      cmd_drop_r <= 1'b0;
    end else begin
      cmd_go_r   <= go;
      cmd_drop_r <= drop;
      event_r    <= event_nxt;
      if (cmd_valid) begin
        last_op_r <= cmd_opcode;
      end
      if (busy_r && op_done) begin
        busy_r <= 1'b0;
        wel_r  <= 1'b0;
      end else if (go) begin
        if (cls == CL_WRITE_ENABLE_CMD) begin
          wel_r <= 1'b1;
        end else if (cls == CL_WRDI) begin
          wel_r <= 1'b0;
        end
        if (starts_long) begin
          busy_r <= 1'b1;
        end
        if (cls == CL_STATUS_WRITE_CMD) begin
          bp_r   <= cmd_data[`FWP_ST_BP_HI:`FWP_ST_BP_LO];
          qe_r   <= cmd_data[`FWP_ST_QE];
          status_write_disable_r <= cmd_data[`FWP_ST_STATUS_WRITE_DISABLE];
        end
        if (cls == CL_WRFR && cmd_data[`FWP_FN_TBS]) begin
          tbs_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // status and pin-function outputs
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r      <= `FWP_ST_RST;
      quad_lanes_r  <= 1'b0;
      hold_active_r <= 1'b0;
      wp_active_r   <= 1'b0;
    end else begin
      status_r      <= {status_write_disable_r, qe_r, bp_r, wel_r, busy_r};
      quad_lanes_r  <= qe_r;
      // hold and protect functions only while the pins are not data lanes
      hold_active_r <= ~qe_r & ~hold_level_r;
      wp_active_r   <= hw_locked;
    end
  end

  // ==========================================
  // apb slave: read data captured in setup, one wait-free access phase
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup & ~addr_hit;
      if (apb_setup) begin
        case (paddr[3:0])
          `FWP_A_STATUS: prdata_r <= {24'h000000, status_r};
          `FWP_A_FUNC:   prdata_r <= {30'h00000000, tbs_r, 1'b0};
          `FWP_A_EVENT:  prdata_r <= {27'h0000000, event_r};
          `FWP_A_LAST:   prdata_r <= {4'h0, prot_count, 8'h00, last_op_r};
          default:       prdata_r <= 32'h00000000;
        endcase
      end else begin
        prdata_r <= 32'h00000000;
      end
    end
  end

endmodule // fwp_write_protect

// File: fwp_write_protect_asserts.sv
`timescale 1ns/1ps
// ==========
// protection checker
module fwp_write_protect_asserts (
  input logic       ref_clk,
  input logic       reset_n,
  input logic       cmd_valid,
  input logic [7:0] cmd_opcode,
  input logic       op_done,
  input logic       cmd_go_r,
  input logic       cmd_drop_r,
  input logic [7:0] status_r,
  input logic       quad_lanes_r,
  input logic       hold_active_r,
  input logic       wp_active_r
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  logic gated;
  // status_r trails by one edge, so a go in the same cycle masks AST_NO_WEL, AST_ALT_FREE, AST_CE_LOCK and AST_SR_OPEN
  assign gated = cmd_opcode inside {8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20,
    8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83,
    8'h43, 8'h4a, 8'h18, 8'hc5, 8'hfb, 8'he1, 8'hfd, 8'he3, 8'he4};

  sequence s_wel_go;
    cmd_go_r && $past(cmd_opcode) == 8'h06;
  endsequence
  sequence s_alt_req;
    cmd_valid && cmd_opcode inside {8'hc0, 8'h17} && !status_r[0] && !cmd_go_r;
  endsequence

  AST_WEL_SET: assert property (s_wel_go |=> status_r[1])
    else $error("latch not set after write enable");
  AST_NO_WEL: assert property (
    cmd_valid && gated && !status_r[1] && !cmd_go_r |=> !cmd_go_r)
    else $error("gated opcode ran with latch clear");
  AST_ALT_FREE: assert property (s_alt_req |=> cmd_go_r)
    else $error("alternate volatile opcode refused");
  AST_CE_LOCK: assert property (
    cmd_valid && cmd_opcode inside {8'hc7, 8'h60} && status_r[5:2] != 4'h0 && !cmd_go_r
    |=> cmd_drop_r)
    else $error("chip erase ran with protect code set");
  AST_SR_LOCK: assert property (
    cmd_valid && cmd_opcode == 8'h01 && status_r[7] && wp_active_r |=> cmd_drop_r)
    else $error("status write ran while locked");
  AST_SR_OPEN: assert property (
    cmd_valid && cmd_opcode == 8'h01 && status_r[1:0] == 2'b10 && !status_r[7] && !cmd_go_r
    |=> cmd_go_r)
    else $error("status write refused while open");
  AST_WEL_DONE: assert property (op_done && status_r[0] |-> ##2 status_r[1:0] == 2'b00)
    else $error("latch or busy not cleared at completion");
  AST_QUAD: assert property (quad_lanes_r |-> !hold_active_r && !wp_active_r)
    else $error("pin function active while pins are data lanes");
  AST_GO_DROP: assert property (cmd_go_r |-> !cmd_drop_r)
    else $error("go and drop together");
endmodule // fwp_write_protect_asserts

bind fwp_write_protect fwp_write_protect_asserts u_fwp_chk (.ref_clk, .reset_n, .cmd_valid,
  .cmd_opcode, .op_done, .cmd_go_r, .cmd_drop_r, .status_r, .quad_lanes_r, .hold_active_r,
  .wp_active_r);

// File: fwp_host_model.sv
`timescale 1ns/1ps
// ==========
// instruction source and completion timer
module fwp_host_model #(
  parameter DONE_DLY = 4,
  parameter ADDR_W   = 27
) (
  input  logic              ref_clk,
  input  logic              reset_n,
  input  logic [7:0]        status_r,
  output logic              cmd_valid,
  output logic [7:0]        cmd_opcode,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [7:0]        cmd_data,
  output logic              op_done
);
  logic [7:0] busy_cnt_r;

  initial begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_addr = '0;
    cmd_data = 8'h00;
  end

  task send(input logic [7:0] op, input logic [ADDR_W-1:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_addr <= addr;
    cmd_data <= data;
    @(posedge ref_clk);
    // fields mean nothing outside the pulse; scramble them so no one leans on stale values
    cmd_valid <= 1'b0;
    cmd_opcode <= ~op;
    cmd_addr <= ~addr;
    cmd_data <= ~data;
  endtask

  // completion a fixed time after busy shows, once per operation
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_r <= 8'h00;
      op_done <= 1'b0;
    end else begin
      op_done <= status_r[0] && (busy_cnt_r == DONE_DLY);
      if (!status_r[0])
        busy_cnt_r <= 8'h00;
      else if (busy_cnt_r != 8'hff)
        busy_cnt_r <= busy_cnt_r + 8'h01;
    end
  end
endmodule // fwp_host_model

// File: fwp_write_protect_tb_top.sv
`timescale 1ns/1ps
// ==========
// bench top
module fwp_write_protect_tb_top;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic        wp_n_pin = 1'b1;
  logic        hold_n_pin = 1'b1;
  logic [31:0] prdata_r, rd;
  logic        pready_r, pslverr_r, cmd_valid, op_done, cmd_go_r, cmd_drop_r, e;
  logic        tbs_r, quad_lanes_r, hold_active_r, wp_active_r;
  logic [7:0]  cmd_opcode, cmd_data, status_r;
  logic [26:0] cmd_addr;
  int          failures = 0;
  int          checks = 0;
  logic [7:0]  gated [30] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20, 8'h21,
    8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h43,
    8'h4a, 8'h18, 8'hc5, 8'hfb, 8'he1, 8'hfd, 8'he3, 8'he4};

  always #10 ref_clk = ~ref_clk;

  fwp_write_protect dut (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_r, .pready_r, .pslverr_r, .cmd_valid, .cmd_opcode, .cmd_addr, .cmd_data, .op_done,
    .wp_n_pin, .hold_n_pin, .cmd_go_r, .cmd_drop_r, .status_r, .tbs_r, .quad_lanes_r,
    .hold_active_r, .wp_active_r);
  fwp_host_model #(.DONE_DLY(4)) hm (.ref_clk, .reset_n, .status_r, .cmd_valid, .cmd_opcode,
    .cmd_addr, .cmd_data, .op_done);

  // ==========
  // helpers
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready_r !== 1'b1 && n < 50);
    if (pready_r !== 1'b1)
      failures++;
    rd = prdata_r;
    e = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // checks the verdict, then lets any long operation run out
  task op(input logic [7:0] o, input logic [10:0] blk, input logic [7:0] d, input logic g);
    int n;
    hm.send(o, {blk, 16'h0000}, d);
    // verdict pulse stands only in the cycle right after the command edge
    #1;
    chkb("go", g, cmd_go_r);
    chkb("drop", !g, cmd_drop_r);
    n = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    while (status_r[0] !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (status_r[0] !== 1'b0)
      failures++;
  endtask

  task wop(input logic [7:0] o, input logic [10:0] blk, input logic [7:0] d, input logic g);
    op(8'h06, 11'h0, 8'h00, 1'b1);
    op(o, blk, d, g);
  endtask

  function automatic logic [11:0] blocks(input logic [3:0] c);
    case (c)
      4'h0: blocks = 12'h000;
      4'hc: blocks = 12'h600;
      4'hd: blocks = 12'h700;
      4'he: blocks = 12'h780;
      4'hf: blocks = 12'h800;
      default: blocks = 12'h001 << (c - 4'h1);
    endcase
  endfunction

  // first protected and first free block on each side of the boundary
  task prot_pass(input logic bot);
    logic [11:0] n;
    for (int c = 0; c < 16; c++) begin
      n = blocks(4'(c));
      wop(8'h01, 11'h0, {2'b00, 4'(c), 2'b00}, 1'b1);
      apb(1'b0, 32'hc, 32'h0);
      chk("count", {20'h0, n}, {20'h0, rd[27:16]});
      if (n != 12'h0)
        wop(8'h02, 11'(bot ? n - 12'h1 : 12'h800 - n), 8'h00, 1'b0);
      if (n != 12'h800)
        wop(8'h02, 11'(bot ? n : 12'h7ff - n), 8'h00, 1'b1);
      wop(c[0] ? 8'h60 : 8'hc7, 11'h0, 8'h00, c == 0);
    end
  endtask

  task final_report;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========
  // sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b0, 32'h0, 32'h0);
    chk("status", 32'h0, rd);
    chkb("tbs", 1'b0, tbs_r);
    op(8'hc0, 11'h0, 8'h00, 1'b1);
    op(8'h17, 11'h0, 8'h00, 1'b1);
    op(8'h06, 11'h0, 8'h00, 1'b1);
    op(8'h04, 11'h0, 8'h00, 1'b1);
    op(8'h02, 11'h0, 8'h00, 1'b0);
    foreach (gated[i])
      op(gated[i], 11'h0, 8'h00, 1'b0);
    foreach (gated[i]) begin
      wop(gated[i], 11'h0, 8'h00, 1'b1);
      chkb("wel", gated[i] inside {8'h63, 8'h83, 8'h4a, 8'hc5, 8'hfb, 8'he1}, status_r[1]);
    end
    prot_pass(1'b0);
    wop(8'h42, 11'h0, 8'h02, 1'b1);
    chkb("tbs", 1'b1, tbs_r);
    prot_pass(1'b1);
    wop(8'h42, 11'h0, 8'h00, 1'b1);
    apb(1'b0, 32'h4, 32'h0);
    chkb("tbs", 1'b1, rd[1]);
    wop(8'h01, 11'h0, 8'h80, 1'b1);
    wp_n_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    wop(8'h01, 11'h0, 8'h00, 1'b0);
    chkb("status_write_disable", 1'b1, status_r[7]);
    wp_n_pin <= 1'b1;
    hold_n_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    wop(8'h01, 11'h0, 8'h40, 1'b1);
    chkb("lanes", 1'b1, quad_lanes_r);
    chkb("hold", 1'b0, hold_active_r);
    wop(8'h01, 11'h0, 8'h00, 1'b1);
    repeat (4) @(posedge ref_clk);
    chkb("hold", 1'b1, hold_active_r);
    apb(1'b0, 32'h8, 32'h0);
    chk("event", 32'h0000000f, rd);
    apb(1'b1, 32'h8, 32'h1f);
    apb(1'b0, 32'h8, 32'h0);
    chk("event", 32'h0, rd);
    apb(1'b0, 32'h10, 32'h0);
    chkb("slverr", 1'b1, e);
    final_report();
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    final_report();
  end
endmodule // fwp_write_protect_tb_top
